// ==== pkg/dshi_params.svh ====
`ifndef DSHI_PARAMS_SVH
`define DSHI_PARAMS_SVH

// framed serial word
`define DSHI_FRAME_BITS 5'd24
`define DSHI_FRAME_LAST 5'd23
`define DSHI_BIT_BANK 23
`define DSHI_BIT_RW 22
`define DSHI_CH_HI 21
`define DSHI_CH_LO 16
`define DSHI_REG_HI 15
`define DSHI_REG_LO 14
`define DSHI_HEAD_HI 23
`define DSHI_HEAD_LO 14
`define DSHI_NOP_HI 23
`define DSHI_NOP_LO 2
`define DSHI_PAD_BITS 2'h0

// two-wire slave
`define DSHI_ADDR_FIXED 5'h15
`define DSHI_ACK_BIT 4'h8
`define DSHI_BYTE_ADDR 2'h0
`define DSHI_BYTE_PTR 2'h1
`define DSHI_BYTE_HI 2'h2
`define DSHI_BYTE_LO 2'h3
`define DSHI_PTR_CH_HI 5
`define DSHI_HI_REG_HI 7
`define DSHI_HI_REG_LO 6
`define DSHI_HI_DATA_HI 3
`define DSHI_I2C_MAX_KHZ 400

// buffering
`define DSHI_FIFO_DEPTH 8

`endif

// ==== pkg/dshi_pkg.sv ====
package dshi_pkg;

    typedef struct packed {
        logic bank;
        logic [5:0] channel;
        logic [1:0] reg_sel;
        logic [11:0] data;
    } dshi_word_t;

    typedef enum logic [3:0] {
        I2C_IDLE = 4'b0001,
        I2C_RX = 4'b0010,
        I2C_ACK = 4'b0100,
        I2C_IGNORE = 4'b1000
    } dshi_i2c_state_t;

    // [0] first stage, [1] second stage, [2] previous second stage
    typedef struct packed {
        logic [2:0] sclk;
        logic [2:0] sync_n;
        logic [1:0] din;
        logic [2:0] scl;
        logic [2:0] sda;
        logic [1:0] if_sel;
        logic [1:0] proto_sel;
        logic [1:0] chain;
        logic [1:0] strap_hi;
        logic [1:0] strap_lo;
    } dshi_pins_t;

endpackage : dshi_pkg

// ==== core/dshi_fifo.sv ====
`timescale 1ns/10ps
module dshi_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } dshi_fifo_st_t;

    dshi_fifo_st_t st_ff;
    dshi_fifo_st_t nxt_st;
    logic push;
    logic load;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // output word sits in its own register, so capacity is DEPTH plus one
    always_comb
    begin
        nxt_st = st_ff;
        push = i_in_valid && (st_ff.cnt < (AW+1)'(DEPTH));
        load = (st_ff.cnt != '0) && (!st_ff.ov || i_out_ready);
        if (load)
        begin
            nxt_st.od = st_ff.mem[st_ff.rp];
            nxt_st.rp = ptr_inc(st_ff.rp);
            nxt_st.ov = 1'b1;
        end
        else if (st_ff.ov && i_out_ready)
        begin
            nxt_st.ov = 1'b0;
        end
        if (push)
        begin
            nxt_st.mem[st_ff.wp] = i_in_data;
            nxt_st.wp = ptr_inc(st_ff.wp);
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(load);
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign o_in_ready = st_ff.cnt < (AW+1)'(DEPTH);
    assign o_out_valid = st_ff.ov;
    assign o_out_data = st_ff.od;

endmodule : dshi_fifo

// ==== core/dshi_core.sv ====
`timescale 1ns/10ps
`include "dshi_params.svh"
module dshi_core #(
    parameter int FIFO_DEPTH = `DSHI_FIFO_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_interface_select,
    input wire logic i_protocol_select,
    input wire logic i_chain_enable,
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_din,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_address_strap_hi,
    input wire logic i_address_strap_lo,
    input wire logic [11:0] i_rb_data,
    input wire logic i_word_ready,
    output logic o_chained_data_out,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_rb_req,
    output logic [5:0] o_rb_channel,
    output logic [1:0] o_rb_reg,
    output logic o_word_valid,
    output dshi_pkg::dshi_word_t o_word,
    output logic o_overflow,
    output logic o_bad_frame
);

    typedef struct packed {
        dshi_pkg::dshi_pins_t pin;
        logic [23:0] shift;
        logic [4:0] cnt;
        logic active;
        logic seen_fall;
        logic chained_data_out;
        logic rb_wait;
        logic rb_pend;
        logic [9:0] rb_head;
        logic [23:0] rb_word;
        logic rb_req;
        logic [5:0] rb_channel;
        logic [1:0] rb_reg;
        logic push;
        dshi_pkg::dshi_word_t push_word;
        logic overflow;
        logic bad_frame;
        dshi_pkg::dshi_i2c_state_t i2c;
        logic [3:0] bitn;
        logic [1:0] byte_idx;
        logic [7:0] rx;
        logic [7:0] ptr;
        logic [7:0] hi;
        logic sda_oe;
    } dshi_state_t;

    dshi_state_t st_ff;
    dshi_state_t nxt_st;
    logic fifo_in_ready;

    function automatic logic fell(input logic [2:0] p);
        fell = p[2] && !p[1];
    endfunction : fell

    function automatic logic rose(input logic [2:0] p);
        rose = !p[2] && p[1];
    endfunction : rose

    function automatic dshi_pkg::dshi_word_t frame_word(input logic [23:0] f);
        frame_word.bank = f[`DSHI_BIT_BANK];
        frame_word.channel = f[`DSHI_CH_HI:`DSHI_CH_LO];
        frame_word.reg_sel = f[`DSHI_REG_HI:`DSHI_REG_LO];
        frame_word.data = f[`DSHI_REG_LO-1:`DSHI_NOP_LO];
    endfunction : frame_word

    always_comb
    begin
        logic spi_on, i2c_on, standalone, frame_ok, room;
        logic sclk_fall, sclk_rise, sync_fall, sync_rise, scl_fall, scl_rise, start_cond, stop_cond;
        logic [23:0] frame;
        logic [23:0] shifted;
        nxt_st = st_ff;
        spi_on = st_ff.pin.if_sel[1] && !st_ff.pin.proto_sel[1];
        i2c_on = st_ff.pin.if_sel[1] && st_ff.pin.proto_sel[1];
        standalone = !st_ff.pin.chain[1];
        sclk_fall = fell(st_ff.pin.sclk);
        sclk_rise = rose(st_ff.pin.sclk);
        sync_fall = fell(st_ff.pin.sync_n);
        sync_rise = rose(st_ff.pin.sync_n);
        scl_fall = fell(st_ff.pin.scl);
        scl_rise = rose(st_ff.pin.scl);
        start_cond = fell(st_ff.pin.sda) && st_ff.pin.scl[1] && st_ff.pin.scl[2];
        stop_cond = rose(st_ff.pin.sda) && st_ff.pin.scl[1] && st_ff.pin.scl[2];
        shifted = {st_ff.shift[22:0], st_ff.pin.din[1]};
        // a push already in flight has not yet shown in the fifo level
        room = fifo_in_ready && !st_ff.push;
        frame_ok = 1'b0;
        frame = '0;

        // two-flop synchronisers, edges taken between stages two and three
        nxt_st.pin.sclk = {st_ff.pin.sclk[1:0], i_sclk};
        nxt_st.pin.sync_n = {st_ff.pin.sync_n[1:0], i_sync_n};
        nxt_st.pin.din = {st_ff.pin.din[0], i_din};
        nxt_st.pin.scl = {st_ff.pin.scl[1:0], i_scl};
        nxt_st.pin.sda = {st_ff.pin.sda[1:0], i_sda};
        nxt_st.pin.if_sel = {st_ff.pin.if_sel[0], i_interface_select};
        nxt_st.pin.proto_sel = {st_ff.pin.proto_sel[0], i_protocol_select};
        nxt_st.pin.chain = {st_ff.pin.chain[0], i_chain_enable};
        nxt_st.pin.strap_hi = {st_ff.pin.strap_hi[0], i_address_strap_hi};
        nxt_st.pin.strap_lo = {st_ff.pin.strap_lo[0], i_address_strap_lo};

        nxt_st.push = 1'b0;
        nxt_st.rb_req = 1'b0;
        nxt_st.overflow = 1'b0;
        nxt_st.bad_frame = 1'b0;

        // readback source answers in the same cycle as the request
        if (st_ff.rb_wait)
        begin
            nxt_st.rb_word = {st_ff.rb_head, i_rb_data, `DSHI_PAD_BITS};
            nxt_st.rb_pend = 1'b1;
            nxt_st.rb_wait = 1'b0;
        end

        if (!spi_on)
        begin
            nxt_st.active = 1'b0;
        end
        else if (sync_fall)
        begin
            nxt_st.active = 1'b1;
            nxt_st.cnt = '0;
            nxt_st.seen_fall = 1'b0;
            nxt_st.chained_data_out = st_ff.shift[23];
            if (st_ff.rb_pend)
            begin
                nxt_st.shift = st_ff.rb_word;
                nxt_st.chained_data_out = st_ff.rb_word[23];
                nxt_st.rb_pend = 1'b0;
            end
        end
        else if (st_ff.active)
        begin
            if (sync_rise && !standalone)
            begin
                nxt_st.active = 1'b0;
                if (st_ff.cnt == `DSHI_FRAME_BITS)
                begin
                    frame_ok = 1'b1;
                    frame = st_ff.shift;
                end
                else
                begin
                    nxt_st.bad_frame = 1'b1;
                end
            end
            else if (sclk_fall)
            begin
                nxt_st.shift = shifted;
                nxt_st.seen_fall = 1'b1;
                if (st_ff.cnt != `DSHI_FRAME_BITS)
                    nxt_st.cnt = st_ff.cnt + 5'h01;
                if (standalone && st_ff.cnt == `DSHI_FRAME_LAST)
                begin
                    // clock ignored from here until the next sync fall
                    nxt_st.active = 1'b0;
                    frame_ok = 1'b1;
                    frame = shifted;
                end
            end
            else if (sclk_rise && st_ff.seen_fall)
            begin
                // an idle-low clock must not shift out before the first sample
                nxt_st.chained_data_out = st_ff.shift[23];
            end
        end

        if (frame_ok)
        begin
            if (frame[`DSHI_BIT_RW])
            begin
                nxt_st.rb_req = 1'b1;
                nxt_st.rb_channel = frame[`DSHI_CH_HI:`DSHI_CH_LO];
                nxt_st.rb_reg = frame[`DSHI_REG_HI:`DSHI_REG_LO];
                nxt_st.rb_head = frame[`DSHI_HEAD_HI:`DSHI_HEAD_LO];
                nxt_st.rb_wait = 1'b1;
            end
            else if (frame[`DSHI_NOP_HI:`DSHI_NOP_LO] == '0)
            begin
                nxt_st.push = 1'b0;
            end
            else if (room)
            begin
                nxt_st.push = 1'b1;
                nxt_st.push_word = frame_word(frame);
            end
            else
            begin
                nxt_st.overflow = 1'b1;
            end
        end

        if (!i2c_on)
        begin
            nxt_st.i2c = dshi_pkg::I2C_IDLE;
            nxt_st.sda_oe = 1'b0;
        end
        else if (start_cond)
        begin
            nxt_st.i2c = dshi_pkg::I2C_RX;
            nxt_st.bitn = '0;
            nxt_st.byte_idx = `DSHI_BYTE_ADDR;
            nxt_st.sda_oe = 1'b0;
        end
        else if (stop_cond)
        begin
            nxt_st.i2c = dshi_pkg::I2C_IDLE;
            nxt_st.sda_oe = 1'b0;
        end
        else
        begin
            unique case (st_ff.i2c)
                dshi_pkg::I2C_IDLE, dshi_pkg::I2C_IGNORE:
                begin
                    nxt_st.sda_oe = 1'b0;
                end
                dshi_pkg::I2C_RX:
                begin
                    if (scl_rise && st_ff.bitn != `DSHI_ACK_BIT)
                    begin
                        nxt_st.rx = {st_ff.rx[6:0], st_ff.pin.sda[1]};
                        nxt_st.bitn = st_ff.bitn + 4'h1;
                    end
                    else if (scl_fall && st_ff.bitn == `DSHI_ACK_BIT)
                    begin
                        nxt_st.i2c = dshi_pkg::I2C_ACK;
                        nxt_st.sda_oe = 1'b1;
                        unique case (st_ff.byte_idx)
                            `DSHI_BYTE_ADDR:
                            begin
                                nxt_st.byte_idx = `DSHI_BYTE_PTR;
                                if (st_ff.rx != {`DSHI_ADDR_FIXED, st_ff.pin.strap_hi[1],
                                                 st_ff.pin.strap_lo[1], 1'b0})
                                begin
                                    nxt_st.i2c = dshi_pkg::I2C_IGNORE;
                                    nxt_st.sda_oe = 1'b0;
                                end
                            end
                            `DSHI_BYTE_PTR:
                            begin
                                nxt_st.ptr = st_ff.rx;
                                nxt_st.byte_idx = `DSHI_BYTE_HI;
                            end
                            `DSHI_BYTE_HI:
                            begin
                                nxt_st.hi = st_ff.rx;
                                nxt_st.byte_idx = `DSHI_BYTE_LO;
                            end
                            `DSHI_BYTE_LO:
                            begin
                                // a full buffer is refused, the master retries
                                nxt_st.byte_idx = `DSHI_BYTE_PTR;
                                if (room)
                                begin
                                    nxt_st.push = 1'b1;
                                    nxt_st.push_word.bank = 1'b0;
                                    nxt_st.push_word.channel = st_ff.ptr[`DSHI_PTR_CH_HI:0];
                                    nxt_st.push_word.reg_sel = st_ff.hi[`DSHI_HI_REG_HI:`DSHI_HI_REG_LO];
                                    nxt_st.push_word.data = {st_ff.hi[`DSHI_HI_DATA_HI:0], st_ff.rx};
                                end
                                else
                                begin
                                    nxt_st.i2c = dshi_pkg::I2C_IGNORE;
                                    nxt_st.sda_oe = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                dshi_pkg::I2C_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_st.sda_oe = 1'b0;
                        nxt_st.bitn = '0;
                        nxt_st.i2c = dshi_pkg::I2C_RX;
                    end
                end
                default:
                begin
                    nxt_st.i2c = dshi_pkg::I2C_IDLE;
                    nxt_st.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            st_ff <= '0;
            st_ff.i2c <= dshi_pkg::I2C_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    dshi_fifo #(
        .WIDTH($bits(dshi_pkg::dshi_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_in_valid(st_ff.push),
        .i_in_data(st_ff.push_word),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(o_word_valid),
        .o_out_data(o_word),
        .i_out_ready(i_word_ready)
    );

    // the clock line is never driven; data line is open drain, low only
    assign o_sda_out = 1'b0;
    assign o_sda_oe = st_ff.sda_oe;
    assign o_chained_data_out = st_ff.chained_data_out;
    assign o_rb_req = st_ff.rb_req;
    assign o_rb_channel = st_ff.rb_channel;
    assign o_rb_reg = st_ff.rb_reg;
    assign o_overflow = st_ff.overflow;
    assign o_bad_frame = st_ff.bad_frame;

endmodule : dshi_core

// ==== tb/dshi_core_properties.sv ====
`timescale 1ns/10ps
module dshi_core_properties #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_scl,
    input wire logic i_chain_enable,
    input wire logic i_word_ready,
    input wire logic o_chained_data_out,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_rb_req,
    input wire logic [5:0] o_rb_channel,
    input wire logic [1:0] o_rb_reg,
    input wire logic o_word_valid,
    input wire dshi_pkg::dshi_word_t o_word,
    input wire logic o_overflow,
    input wire logic o_bad_frame
);
    logic sclk_ff, sync_ff;
    logic [5:0] rise_ff, fall_ff;
    // pin edges of the last six cycles: sync and detect stages delay the output
    always_ff @(posedge i_core_clk)
    begin
        sclk_ff <= i_sclk;
        sync_ff <= i_sync_n;
        rise_ff <= {rise_ff[4:0], i_sclk & ~sclk_ff};
        fall_ff <= {fall_ff[4:0], sync_ff & ~i_sync_n};
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_ack_slot;
        !i_scl ##0 o_sda_oe [*8];
    endsequence
    a_sda_low_only: assert property (o_sda_out == 1'h0)
        else $error("data line driven high");
    a_ack_start: assert property ($rose(o_sda_oe) |-> s_ack_slot)
        else $error("acknowledge not held through a low clock phase");
    a_ack_release: assert property ($fell(o_sda_oe) |-> !i_scl)
        else $error("acknowledge released while clock high");
    a_dout_edge: assert property ($changed(o_chained_data_out) |-> (|rise_ff) || (|fall_ff))
        else $error("chained output moved without clock rise or sync fall");
    a_rb_pulse: assert property (o_rb_req |=> !o_rb_req)
        else $error("readback request longer than one cycle");
    a_rb_held: assert property ($changed({o_rb_channel, o_rb_reg}) |-> o_rb_req)
        else $error("readback source changed without request");
    a_bad_chain: assert property (o_bad_frame |-> i_chain_enable ##1 !o_bad_frame)
        else $error("bad frame flagged outside chain mode or too long");
    a_word_hold: assert property (o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
        else $error("word changed while stalled");
    a_ovf_pulse: assert property (o_overflow |=> !o_overflow)
        else $error("overflow longer than one cycle");
endmodule : dshi_core_properties

bind dshi_core dshi_core_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.i_core_clk, .i_rstn, .i_sclk,
    .i_sync_n, .i_scl, .i_chain_enable, .i_word_ready, .o_chained_data_out, .o_sda_out, .o_sda_oe,
    .o_rb_req, .o_rb_channel, .o_rb_reg, .o_word_valid, .o_word, .o_overflow, .o_bad_frame);

// ==== tb/dshi_host_model.sv ====
`timescale 1ns/10ps
module dshi_host_model (
    input wire logic i_core_clk,
    input wire logic i_sdo,
    input wire logic i_sda_bus,
    output logic o_sclk,
    output logic o_sync_n,
    output logic o_din,
    output logic o_scl,
    output logic o_sda
);
    initial
    begin
        o_sclk = 1'h1;
        o_sync_n = 1'h1;
        o_din = 1'h0;
        o_scl = 1'h1;
        o_sda = 1'h1;
    end
    task wt(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : wt
    // 80 ns serial clock, idle high; n is 24 per device in the chain
    task frame(input logic [47:0] w, input int n, output logic [47:0] got);
        got = '0;
        o_sync_n = 1'h0;
        for (int i = 0; i < n; i++)
        begin
            o_din = w[47 - i]; // msb first
            wt(8);
            o_sclk = 1'h0;
            got = {got[46:0], i_sdo};
            wt(8);
            o_sclk = 1'h1;
        end
        wt(8);
        o_sync_n = 1'h1; // raised after the last edge
        o_din = ~o_din;
        wt(16);
    endtask : frame
    task i2c_start;
        o_sda = 1'h1;
        wt(8);
        o_scl = 1'h1;
        wt(8);
        o_sda = 1'h0; // falls with clock high
        wt(8);
        o_scl = 1'h0;
        wt(8);
    endtask : i2c_start
    task i2c_byte(input logic [7:0] b, output logic ack);
        for (int i = 0; i < 9; i++)
        begin
            o_sda = (i < 8) ? b[7 - i] : 1'h1; // moves only while clock low
            wt(8);
            o_scl = 1'h1;
            wt(8);
            ack = ~i_sda_bus;
            wt(8);
            o_scl = 1'h0;
            wt(8);
        end
    endtask : i2c_byte
    task i2c_stop;
        o_sda = 1'h0;
        wt(8);
        o_scl = 1'h1;
        wt(8);
        o_sda = 1'h1; // rises with clock high
        wt(16);
    endtask : i2c_stop
endmodule : dshi_host_model

// ==== tb/dshi_core_tb_top.sv ====
`timescale 1ns/10ps
module dshi_core_tb_top;
    logic i_core_clk = 1'h0;
    logic i_rstn = 1'h0;
    logic proto = 1'h0; // framed serial first
    logic sel = 1'h1; // serial interfaces selected
    logic chain = 1'h0;
    logic ready = 1'h0;
    logic [1:0] strap = 2'h0;
    logic sclk, sync_n, din, scl, sda_m, chained_data_out, sda_out, sda_oe, rb_req, valid, ovf, bad, ack;
    logic bad_seen = 1'h0;
    logic ovf_seen = 1'h0;
    logic [5:0] rb_ch;
    logic [1:0] rb_reg;
    logic [47:0] got;
    logic [7:0] tx [7];
    dshi_pkg::dshi_word_t word;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    // register file stand-in: content follows the selected source
    wire [11:0] rb_data = {rb_ch, 2'h0, rb_reg, 2'h3};
    wire sda_bus = sda_m & ~sda_oe;

    initial
    begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    dshi_core i_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_interface_select(sel),
        .i_protocol_select(proto), .i_chain_enable(chain), .i_sclk(sclk), .i_sync_n(sync_n), .i_din(din),
        .i_scl(scl), .i_sda(sda_bus), .i_address_strap_hi(strap[1]), .i_address_strap_lo(strap[0]),
        .i_rb_data(rb_data), .i_word_ready(ready), .o_chained_data_out(chained_data_out), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .o_rb_req(rb_req), .o_rb_channel(rb_ch), .o_rb_reg(rb_reg),
        .o_word_valid(valid), .o_word(word), .o_overflow(ovf), .o_bad_frame(bad));

    dshi_host_model i_host (.i_core_clk(i_core_clk), .i_sdo(chained_data_out), .i_sda_bus(sda_bus), .o_sclk(sclk),
        .o_sync_n(sync_n), .o_din(din), .o_scl(scl), .o_sda(sda_m));

    task check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task wrap_up;
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    function automatic logic [23:0] fr(input logic [5:0] ch, input logic [1:0] rg, input logic [11:0] d);
        fr = {2'h0, ch, rg, d, 2'h0}; // bank sent as 0 without toggle
    endfunction : fr

    task take(input logic [20:0] exp);
        for (int n = 0; n < 60 && valid !== 1'h1; n++)
            i_host.wt(1);
        check(valid, 1'h1);
        check(word, exp);
        ready = 1'h1;
        i_host.wt(1);
        ready = 1'h0;
        i_host.wt(1);
    endtask : take

    task wr(input logic [5:0] ch, input logic [1:0] rg, input logic [11:0] d, input int n);
        i_host.frame({fr(ch, rg, d), 24'h0}, n, got);
        take({1'h0, ch, rg, d});
    endtask : wr

    always @(posedge i_core_clk)
    begin
        cycles++;
        if (bad === 1'h1)
            bad_seen = 1'h1;
        if (ovf === 1'h1)
            ovf_seen = 1'h1;
        if (cycles == 30000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    initial
    begin
        tx = '{8'hAE, 8'h05, 8'h8B, 8'hCD, 8'h21, 8'h43, 8'h4E};
        repeat (2) @(posedge i_core_clk);
        #1 i_rstn = 1'h1;
        i_host.wt(6);
        wr(6'h2A, 2'h2, 12'hABC, 24);
        wr(6'h15, 2'h1, 12'h543, 27);
        i_host.frame({fr(6'h09, 2'h2, 12'h777), 24'h0}, 20, got);
        check(valid, 1'h0);
        check(bad_seen, 1'h0);
        i_host.frame(48'h0, 24, got);
        check(valid, 1'h0);
        i_host.frame({2'h1, 6'h07, 2'h1, 14'h3FFF, 24'h0}, 24, got);
        check({rb_ch, rb_reg}, {6'h07, 2'h1});
        check(valid, 1'h0);
        i_host.frame(48'h0, 24, got);
        check(got[23:0], {2'h1, 6'h07, 2'h1, 6'h07, 2'h0, 2'h1, 2'h3, 2'h0});
        chain = 1'h1;
        i_host.wt(6);
        wr(6'h01, 2'h3, 12'h5A5, 24);
        i_host.frame({fr(6'h0C, 2'h1, 12'h234), fr(6'h06, 2'h2, 12'hDE4)}, 48, got);
        take({1'h0, 6'h06, 2'h2, 12'hDE4});
        check(got[23:0], fr(6'h0C, 2'h1, 12'h234));
        bad_seen = 1'h0;
        i_host.frame({fr(6'h03, 2'h1, 12'h111), 24'h0}, 20, got);
        check(bad_seen, 1'h1);
        check(valid, 1'h0);
        chain = 1'h0;
        i_host.wt(6);
        sel = 1'h0;
        i_host.wt(6);
        i_host.frame({fr(6'h11, 2'h1, 12'h222), 24'h0}, 24, got);
        check(valid, 1'h0);
        sel = 1'h1;
        i_host.wt(6);
        ovf_seen = 1'h0;
        for (int i = 0; i < 10; i++)
        begin
            check(ovf_seen, 1'h0);
            i_host.frame({1'(i), 1'h0, 6'h10, 2'h0, 12'(i), 2'h0, 24'h0}, 24, got);
        end
        check(ovf_seen, 1'h1);
        for (int i = 0; i < 9; i++)
            take({1'(i), 6'h10, 2'h0, 12'(i)});
        i_host.wt(8);
        check(valid, 1'h0);
        proto = 1'h1;
        i_host.wt(6);
        for (int s = 0; s < 4; s++)
        begin
            strap = 2'(s);
            i_host.wt(6);
            i_host.i2c_start();
            i_host.i2c_byte({5'h15, ~strap, 1'h0}, ack);
            check(ack, 1'h0);
            i_host.i2c_start(); // retry after missing acknowledge
            i_host.i2c_byte({5'h15, strap, 1'h0}, ack);
            check(ack, 1'h1);
            i_host.i2c_stop();
        end
        i_host.i2c_start();
        i_host.i2c_byte({5'h15, strap, 1'h1}, ack);
        check(ack, 1'h0);
        i_host.i2c_stop();
        i_host.i2c_start();
        for (int i = 0; i < 7; i++)
        begin
            i_host.i2c_byte(tx[i], ack);
            check(ack, 1'h1);
            if (i == 3)
                take({1'h0, 6'h05, 2'h2, 12'hBCD});
        end
        i_host.i2c_stop();
        take({1'h0, 6'h21, 2'h1, 12'h34E});
        wrap_up();
    end
endmodule : dshi_core_tb_top
